// ==== pwr_state_params.svh ====
// Timing and field constants for the power-state control block
`ifndef PWR_STATE_PARAMS_SVH
`define PWR_STATE_PARAMS_SVH
`define CLK_PERIOD_NS 40
`define CPDED_CYCLES 4'h4
`define PD_MIN_CYCLES 4'h3
`define MAX_SAVE_ENTRY_CYCLES 4'h8
`define CS_HOLD_MIN_NS 12
`define CS_HOLD_MIN_CYCLES ((`CS_HOLD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXIT_LAT_CYCLES 4'h4
`define PAR_EXIT_NS 6
`define PAR_EXIT_CYCLES ((`PAR_EXIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BANK_COUNT 16
`define BANK_IDX_W 4
`define BUSY_W 8
`define ZERO_BUSY 8'h00
`endif

// ==== pwr_state_pkg.sv ====
// Types shared by the power-state control block
`default_nettype none
package pwr_state_pkg;
	typedef enum {
		ST_IDLE, ST_PD_PENDING, ST_PD, ST_PD_EXIT, ST_SAVE_ENTRY, ST_SAVE, ST_SAVE_EXIT, ST_RESET
	} pwr_state_type;
	typedef struct packed {
		logic cs_n;
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} cmd_bus_type;
	typedef struct packed {
		logic in_reset;
		logic precharge_pd;
		logic active_pd;
		logic max_save;
		logic cmd_rx_on;
		logic odt_rx_on;
		logic io_buf_on;
	} pwr_status_type;
endpackage
`default_nettype wire

// ==== pwr_delay_counter.sv ====
// Down counter for fixed cycle delays
`timescale 1ns/1ps
`default_nettype none
`include "pwr_state_params.svh"
module pwr_delay_counter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [3:0] load_value,
	output logic done
);
	logic [3:0] count_reg;
	logic [3:0] count_next;
	assign count_next = load ? load_value : (count_reg != 4'h0 ? count_reg - 4'h1 : 4'h0);
	assign done = (count_reg == 4'h0) && !load;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 4'h0;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule
`default_nettype wire

// ==== pwr_state_ctrl.sv ====
// Power-down and max power saving state control of the memory device
// Functional notes
// R1: Controller uses no-op self refresh exit only with parity and CAL off.
// R2: After self refresh exit only no-ops inside the chip-select hold window.
// R3: No-op is CS low with ACT, RAS, CAS, WE high; device ignores it.
// R4: No-op self refresh exit uses normal exit timing, not fast or abort.
// R5: Power-down entered when CKE registered low with a deselect.
// R6: Controller keeps CKE high during mode writes, ZQ, DLL lock, reads, writes.
// R7: CKE low accepted during activate, precharge, refresh; those finish first.
// R8: Controller resets DLL after exit if it was unlocked at entry.
// R9: Precharge power-down when all banks closed, active power-down otherwise.
// R10: Power-down turns off all buffers except clock, CKE and reset; the code keeps the ODT buffer on in power-down when ODT_OFF_IN_PD is 0.
// R11: ODT mode bit: 0 keeps ODT buffer on, 1 drops nominal termination.
// R12: Command receivers switch off once the disable delay passes after CKE low.
// R13: DLL stays on in both power-downs; commands accepted after exit latency.
// R14: Reset low during power-down leaves it and enters the reset state.
// R15: Controller holds CKE low and high at least the minimum pulse time.
// R16: Controller limits power-down to nine refresh intervals.
// R17: Power-down exits on CKE registered high with a deselect.
// R18: With parity, exit to command delay is max(4 clocks, 6 ns) plus latency.
// R19: Max power saving mode entered by a mode register write.
// R20: Controller disables parity, CAL and gear-down before that write.
// R21: Only deselects until disable delay; then only CS, CKE, reset watched.
// R22: In max power saving the device ignores commands except exit and reset.
// R23: CS low at CKE rise exits max saving and clears its enable bit.
// R24: Controller holds CS low 12 ns to exit time minus 10 ns.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_state_params.svh"
module pwr_state_ctrl
	import pwr_state_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic RESET_N,
	// Command bus
	input wire logic CKE,
	input wire cmd_bus_type CMD,
	// Core state
	input wire logic [`BANK_COUNT-1:0] BANK_OPEN,
	input wire logic [`BUSY_W-1:0] BUSY_DEFERRABLE,
	input wire logic MAX_SAVE_WRITE,
	input wire logic ODT_OFF_IN_PD,
	input wire logic PARITY_EN,
	input wire logic [3:0] PARITY_LATENCY,
	// Status
	output pwr_status_type STATUS,
	output logic MAX_SAVE_ENABLE,
	output logic CMD_READY,
	output logic NOP_SEEN
);
	logic rst_sync1_reg;
	logic rst_sync2_reg;
	logic rst_n;
	pwr_state_type state_reg, state_next;
	logic cke_reg;
	logic enable_reg, enable_next;
	pwr_status_type status_reg, status_next;
	logic ready_reg, ready_next;
	logic nop_reg;
	logic any_bank_open;
	logic busy_any;
	logic is_nop;
	logic is_deselect;
	logic cke_rise;
	logic cke_fall;
	logic dly_load;
	logic [3:0] dly_value;
	logic dly_done;
	logic [3:0] exit_cycles;
	logic [3:0] par_cycles;

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// Per-bank open reduction
	logic [`BANK_COUNT:0] open_chain;
	assign open_chain[0] = 1'b0;
	genvar gi;
	generate
		for (gi = 0; gi < `BANK_COUNT; gi = gi + 1) begin : g_bank
			assign open_chain[gi+1] = open_chain[gi] | BANK_OPEN[gi];
		end
	endgenerate
	assign any_bank_open = open_chain[`BANK_COUNT];
	assign busy_any = BUSY_DEFERRABLE != `ZERO_BUSY;
	assign is_deselect = CMD.cs_n;
	assign is_nop = !CMD.cs_n && CMD.act_n && CMD.ras_n && CMD.cas_n && CMD.we_n; // see R3
	assign cke_rise = CKE && !cke_reg;
	assign cke_fall = !CKE && cke_reg;
	assign par_cycles = (`EXIT_LAT_CYCLES > 4'(`PAR_EXIT_CYCLES)) ? `EXIT_LAT_CYCLES
		: 4'(`PAR_EXIT_CYCLES);
	assign exit_cycles = PARITY_EN ? par_cycles + PARITY_LATENCY : `EXIT_LAT_CYCLES; // see R18

	pwr_delay_counter u_delay (
		.clk(CLK_SYS),
		.rst_n(rst_n),
		.load(dly_load),
		.load_value(dly_value),
		.done(dly_done)
	);

	always_comb begin
		state_next = state_reg;
		enable_next = enable_reg;
		dly_load = 1'b0;
		dly_value = 4'h0;
		ready_next = ready_reg;
		case (state_reg)
			ST_RESET: begin
				if (RESET_N) begin
					state_next = ST_IDLE;
					ready_next = 1'b1;
				end
			end
			ST_IDLE: begin
				if (MAX_SAVE_WRITE) begin
					state_next = ST_SAVE_ENTRY; // see R19
					enable_next = 1'b1;
					ready_next = 1'b0;
					dly_load = 1'b1;
					dly_value = `MAX_SAVE_ENTRY_CYCLES;
				end else if (cke_fall && is_deselect) begin
					state_next = ST_PD_PENDING; // see R5
					ready_next = 1'b0;
					dly_load = 1'b1;
					dly_value = `CPDED_CYCLES;
				end
			end
			ST_PD_PENDING: begin
				if (dly_done && !busy_any) begin
					state_next = ST_PD; // see R7
				end else if (CKE && is_deselect && !busy_any && dly_done) begin
					state_next = ST_PD_EXIT;
				end
			end
			ST_PD: begin
				if (CKE && is_deselect) begin
					state_next = ST_PD_EXIT; // see R17
					dly_load = 1'b1;
					dly_value = exit_cycles; // see R13
				end
			end
			ST_PD_EXIT: begin
				if (dly_done) begin
					state_next = ST_IDLE;
					ready_next = 1'b1;
				end
			end
			ST_SAVE_ENTRY: begin
				if (dly_done) begin
					state_next = ST_SAVE; // see R21
				end
			end
			ST_SAVE: begin
				if (cke_rise && !CMD.cs_n) begin
					state_next = ST_SAVE_EXIT; // see R23
					enable_next = 1'b0;
					dly_load = 1'b1;
					dly_value = exit_cycles;
				end
			end
			ST_SAVE_EXIT: begin
				if (dly_done) begin
					state_next = ST_IDLE;
					ready_next = 1'b1;
				end
			end
			default: begin
				state_next = ST_RESET;
			end
		endcase
		if (!RESET_N) begin
			state_next = ST_RESET; // see R14
			enable_next = 1'b0;
			ready_next = 1'b0;
		end
	end

	always_comb begin
		status_next = '0;
		status_next.in_reset = state_next == ST_RESET;
		status_next.precharge_pd = state_next == ST_PD && !any_bank_open; // see R9
		status_next.active_pd = state_next == ST_PD && any_bank_open;
		status_next.max_save = state_next == ST_SAVE || state_next == ST_SAVE_EXIT;
		status_next.cmd_rx_on = state_next != ST_PD && state_next != ST_SAVE; // see R12
		status_next.io_buf_on = status_next.cmd_rx_on; // see R10
		status_next.odt_rx_on = state_next == ST_PD ? !ODT_OFF_IN_PD
			: status_next.cmd_rx_on; // see R11
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_RESET;
			cke_reg <= 1'b1;
			enable_reg <= 1'b0;
			status_reg <= '0;
			ready_reg <= 1'b0;
			nop_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cke_reg <= CKE;
			enable_reg <= enable_next;
			status_reg <= status_next;
			ready_reg <= ready_next;
			nop_reg <= is_nop && state_reg != ST_SAVE; // see R22
		end
	end

	assign STATUS = status_reg;
	assign MAX_SAVE_ENABLE = enable_reg;
	assign CMD_READY = ready_reg;
	assign NOP_SEEN = nop_reg;

	a_pd_entry: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R5
		(state_reg == ST_IDLE && cke_fall && is_deselect && !MAX_SAVE_WRITE && RESET_N)
		|=> state_reg == ST_PD_PENDING)
		else $error("power-down entry missed");
	a_reset_wins: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R14
		!RESET_N |=> state_reg == ST_RESET && STATUS.in_reset)
		else $error("reset did not force reset state");
	a_pd_kind: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R9
		(state_reg == ST_PD && $past(state_reg) == ST_PD && $stable(BANK_OPEN)
		&& $past(RESET_N)) |-> (STATUS.active_pd == $past(any_bank_open)))
		else $error("wrong power-down kind");
	a_rx_off: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R12
		(state_reg == ST_PD) |=> (!STATUS.cmd_rx_on || state_reg != ST_PD))
		else $error("receivers on in power-down");
	a_save_exit: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R23
		(state_reg == ST_SAVE && cke_rise && !CMD.cs_n && RESET_N)
		|=> !MAX_SAVE_ENABLE && state_reg == ST_SAVE_EXIT)
		else $error("max saving exit failed");
	a_save_stay: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R22
		(state_reg == ST_SAVE && !(cke_rise && !CMD.cs_n) && RESET_N)
		|=> state_reg == ST_SAVE)
		else $error("left max saving wrongly");
	a_entry_delay: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R21
		(state_reg == ST_IDLE && MAX_SAVE_WRITE && RESET_N)
		|=> (state_reg == ST_SAVE_ENTRY || !RESET_N) [*8])
		else $error("entry delay too short");
	a_exit_latency: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R13
		(state_reg == ST_PD_EXIT && RESET_N) |-> ##[1:40] (CMD_READY || state_reg == ST_RESET))
		else $error("exit latency not bounded");
	a_nop_flag: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R3
		(is_nop && state_reg == ST_IDLE) |=> NOP_SEEN && $stable(MAX_SAVE_ENABLE))
		else $error("no-op mishandled");
	a_odt_mode: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // see R11
		(state_next == ST_PD && RESET_N) |=> STATUS.odt_rx_on == !$past(ODT_OFF_IN_PD))
		else $error("odt buffer mode wrong");
	c_pd: cover property (@(posedge CLK_SYS) state_reg == ST_PD ##[1:20] state_reg == ST_IDLE);
	c_save: cover property (@(posedge CLK_SYS) state_reg == ST_SAVE ##1 state_reg == ST_SAVE_EXIT);
	c_reset: cover property (@(posedge CLK_SYS) state_reg == ST_PD ##1 state_reg == ST_RESET);
endmodule
`default_nettype wire

// ==== mem_ctrl_model.sv ====
// Memory controller model driving clock enable and command bus
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model
	import pwr_state_pkg::*;
(
	// Clock
	input wire logic clk,
	// Command side
	output logic cke,
	output cmd_bus_type cmd
);
	initial begin
		cke = 1'b1;
		cmd = 5'h1f;
	end
	// Gear-down stays off, parity only in one power-down test; only deferrable ops run when CKE drops
	// Each level held n cycles, n chosen above the minimum pulse
	// Cs low for one 40 ns cycle, only as a no-op
	task automatic issue(input logic c, input cmd_bus_type k, input int n);
		@(posedge clk);
		cke <= c;
		cmd <= k;
		repeat (n - 1) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Testbench for the power-state control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pwr_state_pkg::*;
;
	localparam cmd_bus_type DES = 5'h1f;
	localparam cmd_bus_type NOP = 5'h0f;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic reset_n = 1'b1;
	logic max_save_write = 1'b0;
	logic odt_off_in_pd = 1'b0;
	logic parity_en = 1'b0;
	logic [15:0] bank_open = 16'h0000;
	logic [7:0] busy = 8'h00;
	logic [3:0] parity_latency = 4'h4;
	wire logic cke;
	wire cmd_bus_type cmd;
	pwr_status_type status;
	logic max_save_enable, cmd_ready, nop_seen;
	int fails = 0;
	int check_count = 0;
	int n0, n1, n2;
	always #20 clk = ~clk;
	mem_ctrl_model ctl (.clk(clk), .cke(cke), .cmd(cmd));
	pwr_state_ctrl DUT (.CLK_SYS(clk), .NRST(nrst), .RESET_N(reset_n), .CKE(cke), .CMD(cmd),
		.BANK_OPEN(bank_open), .BUSY_DEFERRABLE(busy), .MAX_SAVE_WRITE(max_save_write),
		.ODT_OFF_IN_PD(odt_off_in_pd), .PARITY_EN(parity_en), .PARITY_LATENCY(parity_latency),
		.STATUS(status), .MAX_SAVE_ENABLE(max_save_enable), .CMD_READY(cmd_ready),
		.NOP_SEEN(nop_seen));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wait_ready(output int n);
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n < 100, 1'b1, "ready timeout");
	endtask
	task automatic t_nop();
		ctl.issue(1'b1, NOP, 1);
		ctl.issue(1'b1, DES, 1);
		check(nop_seen, 1'b1, "no-op pulse");
		check(cmd_ready, 1'b1, "no-op changed state");
	endtask
	task automatic t_pd(input logic [15:0] b, input logic odt_off, input logic par, output int n);
		@(posedge clk);
		bank_open <= b;
		odt_off_in_pd <= odt_off;
		parity_en <= par;
		ctl.issue(1'b0, DES, 8);
		check(status.precharge_pd, b == 16'h0000, "precharge pd");
		check(status.active_pd, b != 16'h0000, "active pd");
		check(status.cmd_rx_on, 1'b0, "cmd rx on");
		check(status.io_buf_on, 1'b0, "io buf on");
		check(status.odt_rx_on, !odt_off, "odt rx");
		check(cmd_ready, 1'b0, "ready in pd");
		ctl.issue(1'b1, DES, 1);
		wait_ready(n);
		check(status.precharge_pd | status.active_pd, 1'b0, "pd after exit");
	endtask
	task automatic t_busy();
		@(posedge clk);
		busy <= 8'h01;
		ctl.issue(1'b0, DES, 8);
		check(status.precharge_pd, 1'b0, "pd while busy");
		@(posedge clk);
		busy <= 8'h00;
		ctl.issue(1'b0, DES, 8);
		check(status.precharge_pd, 1'b1, "pd after busy");
		ctl.issue(1'b1, DES, 1);
		wait_ready(n0);
	endtask
	task automatic t_reset_pd();
		ctl.issue(1'b0, DES, 8);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(status.in_reset, 1'b1, "reset in pd");
		check(status.precharge_pd, 1'b0, "pd kept in reset");
		@(posedge clk);
		reset_n <= 1'b1;
		ctl.issue(1'b1, DES, 1);
		wait_ready(n0);
	endtask
	task automatic t_save();
		@(posedge clk);
		max_save_write <= 1'b1;
		@(posedge clk);
		max_save_write <= 1'b0;
		ctl.issue(1'b1, DES, 14);
		check(max_save_enable, 1'b1, "save enable");
		check(status.max_save, 1'b1, "save state");
		ctl.issue(1'b1, NOP, 1);
		ctl.issue(1'b1, DES, 1);
		check(nop_seen, 1'b0, "command in save");
		ctl.issue(1'b0, DES, 4);
		ctl.issue(1'b1, DES, 4);
		check(max_save_enable, 1'b1, "left save with cs high");
		ctl.issue(1'b0, DES, 4);
		ctl.issue(1'b1, NOP, 1);
		ctl.issue(1'b1, DES, 6);
		check(max_save_enable, 1'b0, "save exit");
		check(status.max_save, 1'b0, "save state after exit");
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check(status.in_reset, 1'b0, "reset state");
		check(cmd_ready, 1'b1, "ready after reset");
		t_nop();
		t_pd(16'h0000, 1'b1, 1'b0, n0);
		t_pd(16'h0004, 1'b0, 1'b0, n1);
		check(n1, n0, "exit latency differs");
		t_pd(16'h0000, 1'b0, 1'b1, n2);
		check(n2, n0 + parity_latency, "parity exit latency");
		@(posedge clk);
		parity_en <= 1'b0;
		t_busy();
		t_reset_pd();
		t_save();
		conclude();
	end
endmodule
`default_nettype wire
